// ---- oil_pkg.sv ----
package oil_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h0c;
  localparam logic [7:0]  ADDR_ACK       = 8'h10;

  // control word: blocking switch group in bits 7:0
  localparam int          BSG_EXT_RESET  = 5;       // switch 6 of the group
  localparam int          ACK_BIT        = 0;
  localparam logic [7:0]  BSG_RST        = 8'h00;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

  // status word fields
  localparam int          ST_CODE_LSB    = 0;
  localparam int          ST_PHASE_LSB   = 4;
  localparam int          ST_MEM_LSB     = 8;
  localparam int          ST_TRIP        = 12;
  localparam int          ST_LAMP        = 13;
  localparam int          ST_SUPV        = 14;
  localparam int          ST_FTYPE_LSB   = 16;

  // interrupt status bits
  localparam int          IRQ_IND        = 0;
  localparam int          IRQ_LAMP       = 1;
  localparam int          IRQ_SUPPLY     = 2;

  // ****************************************
  // indication codes
  // ****************************************
  localparam int          EV_W           = 10;
  localparam logic [3:0]  CODE_NONE      = 4'h0;
  localparam logic [3:0]  CODE_TH_ALARM  = 4'h1;
  localparam logic [3:0]  CODE_TH_TRIP   = 4'h2;
  localparam logic [3:0]  CODE_INHIBIT   = 4'h3;
  localparam logic [3:0]  CODE_HS_OC     = 4'h4;
  localparam logic [3:0]  CODE_UNBAL     = 4'h5;
  localparam logic [3:0]  CODE_STALL     = 4'h6;
  localparam logic [3:0]  CODE_EF        = 4'h7;
  localparam logic [3:0]  CODE_UNDER     = 4'h8;
  localparam logic [3:0]  CODE_EXT       = 4'h9;
  localparam logic [3:0]  FAULT_RED      = 4'h1;
  // events that are trips and light the trip indicator
  localparam logic [9:0]  TRIP_EV_MASK   = 10'h3f4;

  // ****************************************
  // timing
  // ****************************************
  localparam longint unsigned FAULT_DELAY_S = 64'd120;
  localparam longint unsigned CLK_HZ        = 64'd125_000_000;
  localparam logic [35:0] FAULT_DELAY_CYC   = 36'(FAULT_DELAY_S * CLK_HZ);

  // ****************************************
  // display source
  // ****************************************
  typedef enum logic [1:0] {
    DISP_OFF   = 2'b00,
    DISP_IND   = 2'b01,
    DISP_MEM   = 2'b10,
    DISP_FAULT = 2'b11
  } oil_disp_type;

endpackage

// ---- oil_fault_delay.sv ----
`timescale 1ns/1ps
module oil_fault_delay #(
  parameter logic [35:0] DELAY_CYC = oil_pkg::FAULT_DELAY_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic fault_in,
  output logic      done_r
);
  import oil_pkg::*;

  logic [35:0] cnt_r;

  // ****************************************
  // counts while the fault persists, restarts when it goes
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_r  <= 36'h0;
      done_r <= 1'b0;
    end
    else if (ce)
    begin
      if (!fault_in)
      begin
        cnt_r  <= 36'h0;
        done_r <= 1'b0;
      end
      else if (cnt_r < DELAY_CYC - 36'h1)
        cnt_r <= cnt_r + 36'h1;
      else
        done_r <= 1'b1;
    end
  end

endmodule

// ---- oil_indicator.sv ----
`timescale 1ns/1ps
module oil_indicator #(
  parameter logic [35:0] FAULT_DELAY_CYC = oil_pkg::FAULT_DELAY_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [7:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [31:0]     rdata,
  input  wire logic       lowset_oc_op,
  input  wire logic       thermal_alarm,
  input  wire logic       thermal_trip,
  input  wire logic       restart_inhibit,
  input  wire logic       highset_oc_op,
  input  wire logic       unbalance_trip,
  input  wire logic       stall_trip,
  input  wire logic       earth_fault_stage,
  input  wire logic       undercurrent_trip,
  input  wire logic       external_trip_event,
  input  wire logic       ef_signal_only,
  input  wire logic [3:0] faulty_phase,
  input  wire logic       display_dark,
  input  wire logic       reset_button,
  input  wire logic       ext_control_in,
  input  wire logic       motor_restart,
  input  wire logic       internal_fault,
  input  wire logic [3:0] fault_type,
  input  wire logic       supply_deviation,
  input  wire logic       supply_withdrawn,
  input  wire logic       aux_power_loss,
  output logic            trip_out,
  output logic            trip_led,
  output logic [3:0]      phase_led,
  output logic            digit_red_on,
  output logic [3:0]      digit_red,
  output logic            digits_green_on,
  output logic [3:0]      digit_green,
  output logic            internal_fault_lamp,
  output logic            supervision_out,
  output logic            irq
);
  import oil_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] ev_prev_r;
  logic [EV_W-1:0] ev_rise;
  logic            lowset_prev_r;
  logic            restart_prev_r;
  logic [7:0]      blocking_switch_group_r;
  logic [2:0]      irq_mask_r;
  logic [2:0]      irq_stat_r;
  logic [2:0]      irq_set;
  logic [3:0]      code_r;
  logic [3:0]      mem_r;
  logic            fault_code_r;
  logic [3:0]      fault_type_r;
  logic            lamp_done;
  logic            supply_alarm;
  logic            clr;
  logic            ack_ok;
  logic            phase_op;
  logic            trip_op;
  logic            lamp_prev_r;
  oil_disp_type    disp_src;

  // lowest-numbered rising event
  function automatic logic [3:0] first_code(input logic [EV_W-1:0] v);
    logic [3:0] c;
    c = CODE_NONE;
    for (int i = EV_W - 1; i >= 1; i--)
      if (v[i])
        c = 4'(i);
    return c;
  endfunction

  // ****************************************
  // event inputs and edges
  // ****************************************
  assign ev = {external_trip_event, undercurrent_trip, earth_fault_stage,
               stall_trip, unbalance_trip, highset_oc_op,
               restart_inhibit, thermal_trip, thermal_alarm, 1'b0};
  assign ev_rise  = ev & ~ev_prev_r;
  assign trip_op  = |(ev_rise & TRIP_EV_MASK) | (lowset_oc_op & ~lowset_prev_r);
  assign phase_op = (lowset_oc_op & ~lowset_prev_r) | ev_rise[CODE_HS_OC] | ev_rise[CODE_EF];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ev_prev_r      <= '0;
      lowset_prev_r  <= 1'b0;
      restart_prev_r <= 1'b0;
      lamp_prev_r    <= 1'b0;
    end
    else if (ce)
    begin
      ev_prev_r      <= ev;
      lowset_prev_r  <= lowset_oc_op;
      restart_prev_r <= motor_restart;
      lamp_prev_r    <= lamp_done;
    end
  end

  // clear sources for the indications
  assign clr = reset_button
             | (ext_control_in & blocking_switch_group_r[BSG_EXT_RESET])
             | (motor_restart & ~restart_prev_r);

  // acknowledge allowed for thermal or signalling earth-fault codes
  assign ack_ok = wr && addr == ADDR_ACK && wdata[ACK_BIT]
               && (code_r == CODE_TH_ALARM || code_r == CODE_TH_TRIP
                   || (code_r == CODE_EF && ef_signal_only));

  // ****************************************
  // trip path, unaffected by indications
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      trip_out <= 1'b0;
    else if (ce)
      trip_out <= |(ev & TRIP_EV_MASK) | lowset_oc_op;
  end

  // ****************************************
  // trip indicator and phase leds
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      trip_led <= 1'b0;
    else if (ce)
    begin
      if (trip_op)
        trip_led <= 1'b1;
      else if (clr)
        trip_led <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      phase_led <= 4'h0;
    else if (ce)
    begin
      if (phase_op && display_dark)
        phase_led <= phase_led | faulty_phase;
      else if (clr)
        phase_led <= 4'h0;
    end
  end

  // ****************************************
  // code latch and acknowledge memory
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      code_r <= CODE_NONE;
      mem_r  <= CODE_NONE;
    end
    else if (ce)
    begin
      if (clr)
      begin
        code_r <= CODE_NONE;
        mem_r  <= CODE_NONE;
      end
      else if (ack_ok)
      begin
        mem_r  <= code_r;
        code_r <= CODE_NONE;
      end
      else if (code_r == CODE_NONE && |ev_rise)
        code_r <= first_code(ev_rise);
      else if (code_r == CODE_TH_ALARM && ev_rise[CODE_TH_TRIP])
        code_r <= CODE_TH_TRIP;
    end
  end

  // ****************************************
  // self-supervision
  // ****************************************
  assign supply_alarm = supply_deviation | supply_withdrawn | aux_power_loss;

  oil_fault_delay #(
    .DELAY_CYC (FAULT_DELAY_CYC)
  ) u_delay (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ce       (ce),
    .fault_in (internal_fault),
    .done_r   (lamp_done)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      internal_fault_lamp <= 1'b0;
      supervision_out     <= 1'b0;
    end
    else if (ce)
    begin
      internal_fault_lamp <= lamp_done;
      supervision_out     <= lamp_done | supply_alarm;
    end
  end

  // fault code latch, held while the fault persists
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      fault_code_r <= 1'b0;
      fault_type_r <= 4'h0;
    end
    else if (ce)
    begin
      if (lamp_done && fault_type != 4'h0)
      begin
        fault_code_r <= 1'b1;
        fault_type_r <= fault_type;
      end
      else if (clr && !internal_fault)
        fault_code_r <= 1'b0;
    end
  end

  // ****************************************
  // display
  // ****************************************
  always_comb
  begin
    if (!display_dark)
      disp_src = DISP_OFF;
    else if (fault_code_r)
      disp_src = DISP_FAULT;
    else if (code_r != CODE_NONE)
      disp_src = DISP_IND;
    else if (mem_r != CODE_NONE)
      disp_src = DISP_MEM;
    else
      disp_src = DISP_OFF;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      digit_red_on    <= 1'b0;
      digit_red       <= CODE_NONE;
      digits_green_on <= 1'b0;
      digit_green     <= 4'h0;
    end
    else if (ce)
    begin
      case (disp_src)
        DISP_FAULT:
        begin
          digit_red_on    <= 1'b1;
          digit_red       <= FAULT_RED;
          digits_green_on <= 1'b1;
          digit_green     <= fault_type_r;
        end
        DISP_IND:
        begin
          digit_red_on    <= 1'b1;
          digit_red       <= code_r;
          digits_green_on <= 1'b0;
          digit_green     <= 4'h0;
        end
        DISP_MEM:
        begin
          digit_red_on    <= 1'b1;
          digit_red       <= mem_r;
          digits_green_on <= 1'b0;
          digit_green     <= 4'h0;
        end
        default:
        begin
          digit_red_on    <= 1'b0;
          digit_red       <= CODE_NONE;
          digits_green_on <= 1'b0;
          digit_green     <= 4'h0;
        end
      endcase
    end
  end

  // ****************************************
  // registers, interrupts and read port
  // ****************************************
  assign irq_set = {supply_alarm, lamp_done & ~lamp_prev_r,
                    code_r == CODE_NONE && |ev_rise};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      blocking_switch_group_r <= BSG_RST;
      irq_mask_r              <= IRQ_MASK_RST;
    end
    else if (ce && wr)
    begin
      if (addr == ADDR_CTRL)
        blocking_switch_group_r <= wdata[7:0];
      if (addr == ADDR_IRQ_MASK)
        irq_mask_r <= wdata[2:0];
    end
  end

  // set wins over the write-one clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irq_stat_r <= 3'h0;
    else if (ce)
    begin
      if (wr && addr == ADDR_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~wdata[2:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else if (ce)
      irq <= |(irq_stat_r & irq_mask_r);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rdata <= 32'h0;
    else if (ce)
    begin
      rdata <= 32'h0;
      if (rd)
        case (addr)
          ADDR_CTRL:     rdata <= {24'h0, blocking_switch_group_r};
          ADDR_STATUS:   rdata <= {12'h0, fault_type_r, 1'b0, supervision_out,
                                   internal_fault_lamp, trip_led, mem_r, phase_led, code_r};
          ADDR_IRQ_STAT: rdata <= {29'h0, irq_stat_r};
          ADDR_IRQ_MASK: rdata <= {29'h0, irq_mask_r};
          default:       rdata <= 32'h0;
        endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_ack;
    ce && ack_ok && !clr;
  endsequence

  sequence s_dark_idle;
    ce && display_dark && !fault_code_r && code_r == CODE_NONE && !clr && !(|ev_rise);
  endsequence

  a_trip_led_set: assert property (ce && trip_op |=> trip_led)
    else $error("trip indicator not lit after operation");

  a_trip_led_hold: assert property (ce && trip_led && !clr |=> trip_led)
    else $error("trip indicator dropped without reset");

  a_phase_led_dark: assert property (ce && phase_op && display_dark
      |=> (phase_led & $past(faulty_phase)) == $past(faulty_phase))
    else $error("faulty phase not shown on dark display");

  a_red_alone: assert property (digit_red_on && digit_red != FAULT_RED
      |-> !digits_green_on)
    else $error("indication shown with green digits on");

  a_first_kept: assert property (ce && code_r != CODE_NONE && code_r != CODE_TH_ALARM
      && !clr && !ack_ok |=> code_r == $past(code_r))
    else $error("first indication overwritten");

  a_thermal_upgrade: assert property (ce && code_r == CODE_TH_ALARM
      && ev_rise[CODE_TH_TRIP] && !clr && !ack_ok |=> code_r == CODE_TH_TRIP)
    else $error("prior alarm not replaced by thermal trip");

  a_ack_reshow: assert property (s_ack ##1 s_dark_idle
      |=> digit_red_on && digit_red == $past(mem_r) && mem_r != CODE_NONE)
    else $error("acknowledged indication not shown again");

  a_clear_all: assert property (ce && clr && !trip_op && !phase_op
      |=> code_r == CODE_NONE && !trip_led && phase_led == 4'h0)
    else $error("indications not cleared");

  a_ext_blocked: assert property (ce && ext_control_in && !reset_button
      && !blocking_switch_group_r[BSG_EXT_RESET] && !(motor_restart && !restart_prev_r)
      && trip_led |=> trip_led)
    else $error("external input cleared while switch off");

  a_lamp_cause: assert property ($rose(internal_fault_lamp)
      |-> $past(internal_fault, 2))
    else $error("fault lamp without persistent fault");

  a_fault_code_kept: assert property (ce && fault_code_r && internal_fault
      |=> fault_code_r)
    else $error("fault code reset while fault persists");

  a_supply_alarm: assert property (ce && supply_alarm |=> supervision_out)
    else $error("supply alarm not raised");

endmodule

// ---- oil_partner.sv ----
`timescale 1ns/1ps
// ****************************************
// protection stages and front panel model
// ****************************************
module oil_partner (
  input  wire logic       clk_sys,
  output logic [9:0]      ev_r,
  output logic [3:0]      faulty_phase,
  output logic            display_dark,
  output logic            ef_signal_only,
  output logic [2:0]      clr_r,
  output logic            internal_fault,
  output logic [3:0]      fault_type,
  output logic [2:0]      supply_r
);
  // everything idle at time zero, display dark
  initial
  begin
    ev_r = 10'h000;
    faulty_phase = 4'h0;
    display_dark = 1'b1;
    ef_signal_only = 1'b0;
    clr_r = 3'h0;
    internal_fault = 1'b0;
    fault_type = 4'h0;
    supply_r = 3'h0;
  end

  // a stage changes its level just after an edge; index 0 is low-set
  task automatic stage(input int idx, input logic val);
    @(posedge clk_sys);
    ev_r[idx] <= val;
  endtask

  // clear held n cycles: 0 button, 1 external input, 2 motor restart
  task automatic clear(input int which, input int n);
    @(posedge clk_sys);
    clr_r[which] <= 1'b1;
    repeat (n) @(posedge clk_sys);
    clr_r[which] <= 1'b0;
  endtask
endmodule

// ---- test_oil_indicator.sv ----
`timescale 1ns/1ps
module test_oil_indicator;
  import oil_pkg::*;
  localparam int DLY = 20;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata, r;
  logic [9:0]  ev;
  logic [3:0]  ph, ft, phase_led, digit_red, digit_green;
  logic [2:0]  clr, sup;
  logic        dark, efs, ifault, trip_out, trip_led, digit_red_on;
  logic        digits_green_on, internal_fault_lamp, supervision_out, irq;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          m_code, m_trip, d, n;

  // ****************************************
  // clock, design and partner
  // ****************************************
  always #4 clk_sys = ~clk_sys;

  oil_indicator #(.FAULT_DELAY_CYC(36'd20)) i_oil_indicator (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .lowset_oc_op(ev[0]), .thermal_alarm(ev[1]),
    .thermal_trip(ev[2]), .restart_inhibit(ev[3]), .highset_oc_op(ev[4]),
    .unbalance_trip(ev[5]), .stall_trip(ev[6]), .earth_fault_stage(ev[7]),
    .undercurrent_trip(ev[8]), .external_trip_event(ev[9]), .ef_signal_only(efs),
    .faulty_phase(ph), .display_dark(dark), .reset_button(clr[0]),
    .ext_control_in(clr[1]), .motor_restart(clr[2]), .internal_fault(ifault),
    .fault_type(ft), .supply_deviation(sup[0]), .supply_withdrawn(sup[1]),
    .aux_power_loss(sup[2]), .trip_out(trip_out), .trip_led(trip_led),
    .phase_led(phase_led), .digit_red_on(digit_red_on), .digit_red(digit_red),
    .digits_green_on(digits_green_on), .digit_green(digit_green),
    .internal_fault_lamp(internal_fault_lamp), .supervision_out(supervision_out),
    .irq(irq));

  oil_partner i_oil_partner (
    .clk_sys(clk_sys), .ev_r(ev), .faulty_phase(ph), .display_dark(dark),
    .ef_signal_only(efs), .clr_r(clr), .internal_fault(ifault), .fault_type(ft),
    .supply_r(sup));

  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'h4962));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(1);
    // reset values and an unmapped place
    rd_reg(ADDR_CTRL, r);
    chk(r, {24'h0, BSG_RST});
    rd_reg(ADDR_IRQ_MASK, r);
    chk(r, {29'h0, IRQ_MASK_RST});
    rd_reg(ADDR_STATUS, r);
    chk(r, 32'h0);
    rd_reg(8'h20, r);
    chk(r, 32'h0);
    $display("test reset done");
    // every code, a later event that must not overwrite it
    for (int c = 1; c <= 9; c++)
    begin
      d = 1 + ($urandom % 9);
      if (d == c || (c == 1 && d == 2))
        d = (c == 9) ? 8 : 9;
      m_code = c;
      m_trip = TRIP_EV_MASK[c] | TRIP_EV_MASK[d];
      i_oil_partner.stage(c, 1'b1);
      cyc(3);
      chk(digit_red, m_code);
      chk({digit_red_on, digits_green_on}, 2'b10);
      i_oil_partner.stage(d, 1'b1);
      cyc(3);
      rd_reg(ADDR_STATUS, r);
      chk(r[3:0], m_code);
      i_oil_partner.stage(c, 1'b0);
      i_oil_partner.stage(d, 1'b0);
      cyc(2);
      chk(trip_led, m_trip);
      i_oil_partner.clear(0, 1);
      cyc(3);
      chk({trip_led, digit_red_on}, 2'b00);
    end
    $display("test codes done");
    // prior alarm replaced by thermal trip
    i_oil_partner.stage(1, 1'b1);
    i_oil_partner.stage(2, 1'b1);
    cyc(3);
    chk(digit_red, CODE_TH_TRIP);
    i_oil_partner.stage(1, 1'b0);
    i_oil_partner.stage(2, 1'b0);
    i_oil_partner.clear(0, 3);
    // acknowledge, memory, interrupt mask and clear, restart
    wr_reg(ADDR_IRQ_MASK, 32'h0);
    wr_reg(ADDR_IRQ_STAT, 32'h7);
    i_oil_partner.stage(1, 1'b1);
    cyc(3);
    chk(irq, 1'b0);
    wr_reg(ADDR_IRQ_MASK, 32'h1);
    cyc(2);
    chk(irq, 1'b1);
    wr_reg(ADDR_ACK, 32'h1);
    cyc(3);
    rd_reg(ADDR_STATUS, r);
    chk(r[11:0], 12'h100);
    chk({digit_red_on, digit_red}, 5'h11);
    wr_reg(ADDR_IRQ_STAT, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    i_oil_partner.stage(1, 1'b0);
    i_oil_partner.clear(2, 1);
    cyc(3);
    rd_reg(ADDR_STATUS, r);
    chk(r[11:0], 12'h000);
    $display("test acknowledge done");
    // external clear needs switch 6; trip path runs on regardless
    i_oil_partner.stage(4, 1'b1);
    i_oil_partner.clear(1, 2);
    cyc(2);
    chk({trip_led, digit_red}, 5'h14);
    wr_reg(ADDR_CTRL, 32'h1 << BSG_EXT_RESET);
    i_oil_partner.clear(1, 2);
    cyc(2);
    chk({trip_out, trip_led, digit_red_on}, 3'b100);
    i_oil_partner.stage(4, 1'b0);
    $display("test external clear done");
    // phase leds only with display dark
    @(posedge clk_sys);
    i_oil_partner.faulty_phase <= 4'h1 + 4'($urandom % 15);
    i_oil_partner.stage(0, 1'b1);
    cyc(3);
    chk({trip_led, phase_led}, {1'b1, ph});
    i_oil_partner.stage(0, 1'b0);
    i_oil_partner.clear(0, 1);
    @(posedge clk_sys);
    i_oil_partner.display_dark <= 1'b0;
    i_oil_partner.stage(0, 1'b1);
    cyc(3);
    chk({phase_led, digit_red_on}, 5'h00);
    i_oil_partner.stage(0, 1'b0);
    i_oil_partner.display_dark <= 1'b1;
    i_oil_partner.clear(0, 1);
    $display("test phase done");
    // delayed fault lamp and fault code that resists clearing
    @(posedge clk_sys);
    i_oil_partner.fault_type <= 4'h1 + 4'($urandom % 15);
    i_oil_partner.internal_fault <= 1'b1;
    n = 0;
    while (internal_fault_lamp !== 1'b1 && n < DLY + 40)
    begin
      cyc(1);
      n++;
    end
    if (internal_fault_lamp !== 1'b1)
    begin
      n_mismatch++;
      summarize();
    end
    chk(n >= DLY && n <= DLY + 3, 1'b1);
    cyc(2);
    chk(supervision_out, 1'b1);
    chk({digit_red_on, digit_red, digits_green_on, digit_green}, {1'b1, FAULT_RED, 1'b1, ft});
    i_oil_partner.clear(0, 2);
    cyc(2);
    chk({digits_green_on, digit_green}, {1'b1, ft});
    @(posedge clk_sys);
    i_oil_partner.internal_fault <= 1'b0;
    i_oil_partner.clear(0, 1);
    cyc(4);
    chk({internal_fault_lamp, digits_green_on}, 2'b00);
    $display("test fault done");
    // each supply alarm operates the supervision output
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_sys);
      i_oil_partner.supply_r[k] <= 1'b1;
      cyc(3);
      chk(supervision_out, 1'b1);
      @(posedge clk_sys);
      i_oil_partner.supply_r[k] <= 1'b0;
      cyc(3);
      chk(supervision_out, 1'b0);
    end
    $display("test supply done");
    // clock enable freezes; earth-fault code acknowledged only when signalling
    @(posedge clk_sys);
    ce <= 1'b0;
    i_oil_partner.stage(7, 1'b1);
    cyc(3);
    chk({digit_red_on, trip_led}, 2'b00);
    @(posedge clk_sys);
    ce <= 1'b1;
    cyc(3);
    chk({trip_led, digit_red}, 5'h17);
    wr_reg(ADDR_ACK, 32'h1);
    cyc(2);
    chk({digit_red_on, digit_red}, 5'h17);
    @(posedge clk_sys);
    i_oil_partner.ef_signal_only <= 1'b1;
    wr_reg(ADDR_ACK, 32'h1);
    cyc(2);
    rd_reg(ADDR_STATUS, r);
    chk(r[11:0], {4'h7, ph, 4'h0});
    chk({digit_red_on, digit_red}, 5'h17);
    i_oil_partner.stage(7, 1'b0);
    i_oil_partner.ef_signal_only <= 1'b0;
    i_oil_partner.clear(0, 1);
    $display("test enable done");
    // every interrupt source was latched; write-one clears them
    rd_reg(ADDR_IRQ_STAT, r);
    chk(r, 32'h7);
    wr_reg(ADDR_IRQ_STAT, 32'h7);
    rd_reg(ADDR_IRQ_STAT, r);
    chk({r[2:0], irq}, 4'h0);
    $display("test interrupt done");
    summarize();
  end
endmodule
